// *** fpm_menu_ctrl.sv ***
// Front panel menu controller top level
`timescale 1ns/1ns
`default_nettype none
`include "fpm_cfg.svh"
module fpm_menu_ctrl
    import fpm_pkg::*;
#(
    parameter logic [31:0] TIMEOUT_CYC =
        32'(64'(`FPM_TIMEOUT_S) * 64'(`FPM_CLK_HZ)),
    parameter logic [31:0] TEST_CYC =
        32'(64'(`FPM_TEST_MS) * 64'(`FPM_CLK_HZ) / 64'd1000),
    parameter logic [31:0] VER_CYC =
        32'(64'(`FPM_VER_MS) * 64'(`FPM_CLK_HZ) / 64'd1000),
    parameter logic [31:0] DEB_CYC =
        32'(64'(`FPM_DEBOUNCE_MS) * 64'(`FPM_CLK_HZ) / 64'd1000),
    // Arbitrary version code
    parameter logic [7:0]  FW_VERSION = 8'h10
) (
    input  wire logic          sys_clk_in,
    input  wire logic          rstn_in,
    input  wire fpm_sw_s       sw_raw_in,
    input  wire logic [3:0]    pll_unlock_in,
    input  wire logic          mute_toggle_in,
    input  wire fpm_settings_s nv_data_in,
    output fpm_settings_s      nv_data_out,
    output logic               nv_write_out,
    output fpm_settings_s      applied_out,
    output fpm_state_e         lcd_view_out,
    output fpm_item_e          lcd_item_out,
    output logic [2:0]         lcd_cursor_out,
    output fpm_settings_s      lcd_data_out,
    output logic               lcd_save_yes_out,
    output logic [7:0]         lcd_version_out,
    output logic               alarm_led_out,
    output logic               alarm_relay_out,
    output logic               mute_led_out,
    output logic               remote_led_out
);
    function automatic logic [2:0] cursor_max(input fpm_item_e it);
        case (it)
            IT_FREQ: cursor_max = `FPM_FREQ_CUR_MAX;
            IT_GAIN: cursor_max = `FPM_GAIN_CUR_MAX;
            default: cursor_max = `FPM_FLAG_CUR_MAX;
        endcase
    endfunction : cursor_max

    function automatic logic [3:0] bcd_step(input logic [3:0] d,
                                            input logic up);
        if (up) begin
            bcd_step = (d >= 4'h9) ? 4'h0 : d + 4'h1;
        end else begin
            bcd_step = (d == 4'h0) ? 4'h9 : d - 4'h1;
        end
    endfunction : bcd_step

    fpm_state_e    state_reg;
    fpm_item_e     item_reg;
    logic [2:0]    cursor_reg;
    logic          yes_reg;
    fpm_settings_s work_reg;
    fpm_settings_s comm_reg;
    logic [31:0]   boot_cnt_reg;
    logic [31:0]   idle_cnt_reg;
    fpm_sw_s       ev;
    logic [4:0]    ev_vec;
    logic [4:0]    raw_vec;
    logic          any_ev;
    logic          vert;
    logic          at_marker;
    logic          idle_hit;
    logic          commit;
    logic          in_session;
    logic [5:0]    gain_step;
    logic [5:0]    gain_next;
    logic [2:0]    digit;

    assign raw_vec = sw_raw_in;
    genvar gi;
    generate
        for (gi = 0; gi < `FPM_SW_COUNT; gi++) begin : g_sw
            fpm_switch_filter #(.DEB_CYC(DEB_CYC)) u_filt (
                .sys_clk_in (sys_clk_in),
                .rstn_in    (rstn_in),
                .raw_in     (raw_vec[gi]),
                .press_out  (ev_vec[gi])
            );
        end
    endgenerate
    assign ev = ev_vec;

    assign any_ev     = |ev_vec;
    assign vert       = ev.up | ev.down;
    assign at_marker  = cursor_reg == cursor_max(item_reg);
    // A press in the same cycle counts as activity and cancels the timeout
    assign idle_hit   = idle_cnt_reg >= TIMEOUT_CYC - 32'h1 && !any_ev;
    assign commit     = state_reg == ST_SAVE && ev.confirm && yes_reg;
    assign in_session = state_reg == ST_MENU || state_reg == ST_SAVE;
    assign digit      = 3'(`FPM_FREQ_TOP - cursor_reg);

    // Tens digit steps coarse, units digit fine
    always_comb begin
        gain_step = (cursor_reg == `FPM_GAIN_CUR_TENS) ?
                    `FPM_GAIN_COARSE : `FPM_GAIN_FINE;
        if (ev.up) begin
            gain_next = work_reg.gain_db + gain_step;
            if (gain_next > `FPM_GAIN_MAX) gain_next = `FPM_GAIN_MAX;
        end else begin
            gain_next = work_reg.gain_db - gain_step;
            if (work_reg.gain_db < `FPM_GAIN_MIN + gain_step) begin
                gain_next = `FPM_GAIN_MIN;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            boot_cnt_reg <= 32'h0000_0000;
        end else if (state_reg == ST_TEST || state_reg == ST_VER) begin
            boot_cnt_reg <= boot_cnt_reg + 32'h1;
            if ((state_reg == ST_TEST && boot_cnt_reg >= TEST_CYC - 32'h1)
                || (state_reg == ST_VER && boot_cnt_reg >= VER_CYC - 32'h1))
            begin
                boot_cnt_reg <= 32'h0000_0000;
            end
        end else begin
            boot_cnt_reg <= 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            idle_cnt_reg <= 32'h0000_0000;
        end else if (!in_session || any_ev) begin
            idle_cnt_reg <= 32'h0000_0000;
        end else if (!idle_hit) begin
            idle_cnt_reg <= idle_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= ST_LOAD;
            item_reg  <= IT_FREQ;
            yes_reg   <= 1'b1;
        end else begin
            case (state_reg)
                ST_LOAD: state_reg <= ST_TEST;
                ST_TEST: begin
                    if (boot_cnt_reg >= TEST_CYC - 32'h1) begin
                        state_reg <= ST_VER;
                    end
                end
                ST_VER: begin
                    if (boot_cnt_reg >= VER_CYC - 32'h1) begin
                        state_reg <= ST_NORMAL;
                    end
                end
                ST_NORMAL: begin
                    if (ev.confirm) begin
                        state_reg <= ST_MENU;
                        item_reg  <= IT_FREQ;
                    end
                end
                ST_MENU: begin
                    if (idle_hit) begin
                        state_reg <= ST_NORMAL;
                    end else if (ev.confirm) begin
                        if (at_marker || item_reg == IT_ADDR) begin
                            state_reg <= ST_SAVE;
                            yes_reg   <= 1'b1;
                        end else begin
                            item_reg <= fpm_item_e'(item_reg + 3'h1);
                        end
                    end
                end
                ST_SAVE: begin
                    if (idle_hit) begin
                        state_reg <= ST_NORMAL;
                    end else if (ev.confirm) begin
                        state_reg <= ST_DONE;
                    end else if (vert) begin
                        yes_reg <= ~yes_reg;
                    end
                end
                ST_DONE: begin
                    if (ev.confirm) begin
                        state_reg <= ST_NORMAL;
                    end
                end
                default: state_reg <= ST_LOAD;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cursor_reg <= 3'h0;
        end else if (state_reg != ST_MENU || ev.confirm) begin
            cursor_reg <= 3'h0;
        end else if (ev.right && !at_marker) begin
            cursor_reg <= cursor_reg + 3'h1;
        end else if (ev.left && cursor_reg != 3'h0) begin
            cursor_reg <= cursor_reg - 3'h1;
        end
    end

    // Working copy: edits live here, gain is driven from it at once
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            work_reg <= '0;
        end else begin
            if (state_reg == ST_LOAD || state_reg == ST_NORMAL
                || (in_session && idle_hit)
                || (state_reg == ST_SAVE && ev.confirm && !yes_reg))
            begin
                work_reg <= (state_reg == ST_LOAD) ? nv_data_in : comm_reg;
            end else if (state_reg == ST_MENU && vert && !at_marker) begin
                case (item_reg)
                    IT_FREQ: work_reg.freq_bcd[digit] <=
                        bcd_step(work_reg.freq_bcd[digit], ev.up);
                    IT_GAIN: work_reg.gain_db <= gain_next;
                    IT_REMOTE: work_reg.remote_op <= ~work_reg.remote_op;
                    IT_EXTREF: begin
                        work_reg.ext_ref <= ~work_reg.ext_ref;
                    end
                    IT_RMODE: work_reg.remote_485 <= ~work_reg.remote_485;
                    IT_ADDR: work_reg.bus_addr <= ev.up ?
                        work_reg.bus_addr + 5'h01 : work_reg.bus_addr - 5'h01;
                    default: work_reg <= work_reg;
                endcase
            end
            if (mute_toggle_in) begin
                work_reg.mute <= ~comm_reg.mute;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            comm_reg         <= '0;
            comm_reg.gain_db <= `FPM_GAIN_RESET;
        end else if (state_reg == ST_LOAD) begin
            comm_reg <= nv_data_in;
        end else if (commit) begin
            comm_reg      <= work_reg;
            comm_reg.mute <= comm_reg.mute ^ mute_toggle_in;
        end else if (mute_toggle_in) begin
            comm_reg.mute <= ~comm_reg.mute;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            nv_write_out <= 1'b0;
            nv_data_out  <= '0;
        end else begin
            nv_write_out <= commit || mute_toggle_in;
            nv_data_out  <= comm_reg;
            if (commit) begin
                nv_data_out      <= work_reg;
                nv_data_out.mute <= comm_reg.mute ^ mute_toggle_in;
            end else if (mute_toggle_in) begin
                nv_data_out.mute <= ~comm_reg.mute;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            applied_out <= '0;
        end else begin
            applied_out <= comm_reg;
            if (in_session || state_reg == ST_DONE) begin
                applied_out.gain_db <= work_reg.gain_db;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            alarm_led_out   <= 1'b0;
            alarm_relay_out <= 1'b0;
            mute_led_out    <= 1'b0;
            remote_led_out  <= 1'b0;
        end else begin
            alarm_led_out   <= |pll_unlock_in;
            alarm_relay_out <= |pll_unlock_in;
            mute_led_out    <= comm_reg.mute;
            remote_led_out  <= comm_reg.remote_op;
        end
    end

    assign lcd_view_out     = state_reg;
    assign lcd_item_out     = item_reg;
    assign lcd_cursor_out   = cursor_reg;
    assign lcd_data_out     = work_reg;
    assign lcd_save_yes_out = yes_reg;
    assign lcd_version_out  = FW_VERSION;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    a_alarm_shared: assert property (
        ##1 (alarm_led_out == $past(|pll_unlock_in))
            && (alarm_relay_out == alarm_led_out))
        else $error("alarm outputs do not follow lock inputs");
    a_boot_order: assert property (
        state_reg == ST_TEST |=> state_reg inside {ST_TEST, ST_VER})
        else $error("segment test not followed by version");
    a_enter_confirm: assert property (
        state_reg == ST_NORMAL && !ev.confirm |=> state_reg == ST_NORMAL)
        else $error("session opened without confirm");
    a_timeout_revert: assert property (
        state_reg == ST_MENU && idle_hit |=>
            state_reg == ST_NORMAL ##1 work_reg.freq_bcd == comm_reg.freq_bcd)
        else $error("idle timeout did not discard edits");
    a_cursor_right: assert property (
        state_reg == ST_MENU && ev.right && !ev.confirm && !at_marker
            |=> cursor_reg == $past(cursor_reg) + 3'h1)
        else $error("cursor did not move right by one");
    a_toggle_flag: assert property (
        state_reg == ST_MENU && item_reg == IT_EXTREF && vert && !at_marker
            |=> work_reg.ext_ref != $past(work_reg.ext_ref))
        else $error("on/off item did not toggle");
    a_freq_hold: assert property (
        state_reg != ST_LOAD && !commit |=>
            ##1 applied_out.freq_bcd == $past(comm_reg.freq_bcd, 2))
        else $error("frequency applied without save");
    a_gain_coarse: assert property (
        state_reg == ST_MENU && item_reg == IT_GAIN && ev.up
            && cursor_reg == `FPM_GAIN_CUR_TENS
            && work_reg.gain_db <= `FPM_GAIN_MAX - `FPM_GAIN_COARSE
            |=> ##1 applied_out.gain_db == $past(work_reg.gain_db, 2)
                + `FPM_GAIN_COARSE)
        else $error("gain tens step wrong or not applied");
    a_save_yes: assert property (
        commit |=> comm_reg.gain_db == $past(work_reg.gain_db)
            && nv_write_out && state_reg == ST_DONE)
        else $error("yes answer did not commit settings");
    a_item_next: assert property (
        state_reg == ST_MENU && ev.confirm && !at_marker && !idle_hit
            && item_reg != IT_ADDR |=> item_reg == $past(item_reg) + 3'h1)
        else $error("confirm did not advance the item");
    a_done_return: assert property (
        state_reg == ST_DONE && ev.confirm |=> state_reg == ST_NORMAL)
        else $error("confirm after answer did not return");

    c_boot_done: cover property (state_reg == ST_VER ##1
        state_reg == ST_NORMAL);
    c_commit: cover property (commit);
    c_revert: cover property (state_reg == ST_SAVE && ev.confirm
        && !yes_reg);
    c_timeout: cover property (in_session && idle_hit);
endmodule : fpm_menu_ctrl
`default_nettype wire

// *** fpm_cfg.svh ***
// Constants of the front panel menu controller
// Notes on behaviour
// - Keep committed settings, restore after power loss
// - Boot: segment test, version, then normal display
// - About 30 s idle discards pending edits
// - Session opens and commits only by confirm
// - Horizontal press moves cursor one place
// - Vertical press steps digit under cursor
// - Vertical press toggles on/off items, any direction
// - Edited frequency applied only after saving
// - Gain acts at once, stored only on yes
// - Gain steps 1 dB units, 10 dB tens
// - Return marker opens save prompt; yes/no
// - Confirm on an item advances to next item
// - Confirm after answer returns to normal display
// - Alarm whenever any oscillator loop unlocks
// - Mute and remote LEDs follow their selections
// - Fixed item order ending in save prompt
`ifndef FPM_CFG_SVH
`define FPM_CFG_SVH
`define FPM_CLK_HZ        125000000
`define FPM_TIMEOUT_S     30
`define FPM_TEST_MS       1000
`define FPM_VER_MS        1000
`define FPM_DEBOUNCE_MS   10
`define FPM_GAIN_MIN      6'h14
`define FPM_GAIN_MAX      6'h32
`define FPM_GAIN_FINE     6'h01
`define FPM_GAIN_COARSE   6'h0A
`define FPM_GAIN_RESET    6'h14
`define FPM_FREQ_TOP      3'h6
`define FPM_FREQ_CUR_MAX  3'h7
`define FPM_GAIN_CUR_MAX  3'h2
`define FPM_FLAG_CUR_MAX  3'h1
`define FPM_GAIN_CUR_TENS 3'h0
`define FPM_GAIN_CUR_UNIT 3'h1
`define FPM_SW_COUNT      5
`endif

// *** fpm_pkg.sv ***
// Types of the front panel menu controller
package fpm_pkg;
    typedef enum logic [2:0] {
        ST_LOAD   = 3'b000,
        ST_TEST   = 3'b001,
        ST_VER    = 3'b010,
        ST_NORMAL = 3'b011,
        ST_MENU   = 3'b100,
        ST_SAVE   = 3'b101,
        ST_DONE   = 3'b110
    } fpm_state_e;

    typedef enum logic [2:0] {
        IT_FREQ   = 3'b000,
        IT_GAIN   = 3'b001,
        IT_REMOTE = 3'b010,
        IT_EXTREF = 3'b011,
        IT_RMODE  = 3'b100,
        IT_ADDR   = 3'b101
    } fpm_item_e;

    typedef struct packed {
        logic [6:0][3:0] freq_bcd;
        logic [5:0]      gain_db;
        logic            remote_op;
        logic            ext_ref;
        logic            remote_485;
        logic [4:0]      bus_addr;
        logic            mute;
    } fpm_settings_s;

    typedef struct packed {
        logic confirm;
        logic left;
        logic right;
        logic up;
        logic down;
    } fpm_sw_s;
endpackage : fpm_pkg

// *** fpm_switch_filter.sv ***
// Debounce and press detection for one panel switch
`timescale 1ns/1ns
`default_nettype none
module fpm_switch_filter #(
    parameter logic [31:0] DEB_CYC = 32'h0001_312D
) (
    input  wire logic sys_clk_in,
    input  wire logic rstn_in,
    input  wire logic raw_in,
    output logic      press_out
);
    logic [31:0] cnt_reg;
    logic        level_reg;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_reg   <= 32'h0000_0000;
            level_reg <= 1'b0;
            press_out <= 1'b0;
        end else begin
            press_out <= 1'b0;
            if (raw_in == level_reg) begin
                cnt_reg <= 32'h0000_0000;
            end else if (cnt_reg >= DEB_CYC - 32'h1) begin
                cnt_reg   <= 32'h0000_0000;
                level_reg <= raw_in;
                press_out <= raw_in;
            end else begin
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end
endmodule : fpm_switch_filter
`default_nettype wire

// *** fpm_panel_model.sv ***
// Panel model: operator switches and retained settings store
`timescale 1ns/1ns
`default_nettype none
module fpm_panel_model
    import fpm_pkg::*;
#(
    parameter int DEB = 3
) (
    input  wire logic          sys_clk_in,
    input  wire logic          nv_write_in,
    input  wire fpm_settings_s nv_data_in,
    output fpm_sw_s            sw_out,
    output fpm_settings_s      store_out,
    output int                 writes_out
);
    initial begin
        sw_out = '0;
        writes_out = 0;
    end

    // Store survives resets; only a write pulse changes it
    always @(posedge sys_clk_in) begin
        if (nv_write_in === 1'b1) begin
            store_out <= nv_data_in;
            writes_out <= writes_out + 1;
        end
    end

    // Hold one switch for len cycles, then leave it released long enough
    task automatic act(input int idx, input int len);
        @(negedge sys_clk_in);
        sw_out[idx] = 1'b1;
        repeat (len) @(negedge sys_clk_in);
        sw_out[idx] = 1'b0;
        repeat (DEB + 3) @(negedge sys_clk_in);
    endtask : act
endmodule : fpm_panel_model
`default_nettype wire

// *** fpm_menu_ctrl_bench.sv ***
// Self-checking bench of the front panel menu controller
`timescale 1ns/1ns
`default_nettype none
module fpm_menu_ctrl_bench;
    import fpm_pkg::*;
    localparam int DEB = 3;
    localparam int TMO = 200;
    localparam int C = 4, L = 3, R = 2, U = 1, D = 0;
    logic          sys_clk;
    logic          rstn;
    fpm_sw_s       sw;
    logic [3:0]    pll_unlock;
    logic          mute_pulse;
    fpm_settings_s nv_in;
    fpm_settings_s nv_out;
    logic          nv_wr;
    fpm_settings_s applied;
    fpm_state_e    view;
    fpm_item_e     item;
    logic [2:0]    cursor;
    fpm_settings_s lcd;
    logic          save_yes;
    logic [7:0]    version;
    logic          alarm_led;
    logic          alarm_relay;
    logic          mute_led;
    logic          remote_led;
    int            writes;
    int            bad_count;
    int            cmp_count;
    int            w0;
    fpm_settings_s exp_s;

    fpm_menu_ctrl #(
        .TIMEOUT_CYC (32'h0000_00C8),
        .TEST_CYC    (32'h0000_0004),
        .VER_CYC     (32'h0000_0004),
        .DEB_CYC     (32'h0000_0003)
    ) i_dut (
        .sys_clk_in       (sys_clk),
        .rstn_in          (rstn),
        .sw_raw_in        (sw),
        .pll_unlock_in    (pll_unlock),
        .mute_toggle_in   (mute_pulse),
        .nv_data_in       (nv_in),
        .nv_data_out      (nv_out),
        .nv_write_out     (nv_wr),
        .applied_out      (applied),
        .lcd_view_out     (view),
        .lcd_item_out     (item),
        .lcd_cursor_out   (cursor),
        .lcd_data_out     (lcd),
        .lcd_save_yes_out (save_yes),
        .lcd_version_out  (version),
        .alarm_led_out    (alarm_led),
        .alarm_relay_out  (alarm_relay),
        .mute_led_out     (mute_led),
        .remote_led_out   (remote_led)
    );

    fpm_panel_model #(.DEB(DEB)) i_panel (
        .sys_clk_in  (sys_clk),
        .nv_write_in (nv_wr),
        .nv_data_in  (nv_out),
        .sw_out      (sw),
        .store_out   (nv_in),
        .writes_out  (writes)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        cmp_count++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] %0t seen %0h want %0h", $time, seen, want);
        end
    endtask : check

    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task automatic cycles(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cycles

    task automatic wait_view(input fpm_state_e v, input int lim);
        repeat (lim) begin
            @(negedge sys_clk);
            if (view === v) return;
        end
        bad_count++;
        $display("[ERR] %0t display state wait ran out", $time);
        results();
    endtask : wait_view

    task automatic press(input int idx);
        i_panel.act(idx, DEB + 3);
    endtask : press

    // Power cycle: storage keeps its content across the reset
    task automatic do_reset;
        rstn = 1'b0;
        cycles(6);
        check(view, ST_LOAD);
        rstn = 1'b1;
        wait_view(ST_TEST, 20);
        wait_view(ST_VER, 20);
        wait_view(ST_NORMAL, 20);
        check(applied, exp_s);
        check(lcd, exp_s);
        check(remote_led, exp_s.remote_op);
    endtask : do_reset

    initial begin
        rstn = 1'b0;
        pll_unlock = 4'h0;
        mute_pulse = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        exp_s = '0;
        exp_s.freq_bcd = 28'h305_0125;
        exp_s.gain_db = 6'h1E;
        exp_s.remote_op = 1'b1;
        exp_s.bus_addr = 5'h05;
        i_panel.store_out = exp_s;
        do_reset();
        check(version, 8'h10);
        i_panel.act(C, 1);
        check(view, ST_NORMAL);
        $display("test boot end");

        w0 = writes;
        press(C);
        check(view, ST_MENU);
        check(item, IT_FREQ);
        check(cursor, 3'h0);
        press(U);
        check(lcd.freq_bcd, 28'h405_0125);
        check(applied.freq_bcd, 28'h305_0125);
        press(R);
        check(cursor, 3'h1);
        press(D);
        check(lcd.freq_bcd, 28'h495_0125);
        press(L);
        check(cursor, 3'h0);
        press(C);
        check(item, IT_GAIN);
        press(U);
        check(applied.gain_db, 6'h28);
        press(R);
        press(U);
        check(applied.gain_db, 6'h29);
        check(writes, w0);
        press(C);
        check(item, IT_REMOTE);
        press(U);
        check(lcd.remote_op, 1'b0);
        press(D);
        check(lcd.remote_op, 1'b1);
        press(C);
        check(item, IT_EXTREF);
        press(D);
        check(lcd.ext_ref, 1'b1);
        press(C);
        check(item, IT_RMODE);
        press(U);
        check(lcd.remote_485, 1'b1);
        press(C);
        check(item, IT_ADDR);
        press(U);
        press(C);
        check(view, ST_SAVE);
        check(save_yes, 1'b1);
        press(D);
        check(save_yes, 1'b0);
        press(U);
        press(C);
        exp_s.freq_bcd = 28'h495_0125;
        exp_s.gain_db = 6'h29;
        exp_s.ext_ref = 1'b1;
        exp_s.remote_485 = 1'b1;
        exp_s.bus_addr = 5'h06;
        check(view, ST_DONE);
        check(writes, w0 + 1);
        check(nv_in, exp_s);
        check(applied, exp_s);
        press(C);
        check(view, ST_NORMAL);
        check(lcd, exp_s);
        $display("test commit end");

        press(C);
        press(U);
        for (int i = 0; i < 7; i++) begin
            press(R);
        end
        check(cursor, 3'h7);
        press(C);
        check(view, ST_SAVE);
        press(U);
        check(save_yes, 1'b0);
        press(C);
        check(applied, exp_s);
        check(writes, w0 + 1);
        press(C);
        check(lcd, exp_s);
        $display("test discard end");

        press(C);
        press(C);
        press(U);
        check(applied.gain_db, 6'h32);
        cycles(TMO - 40);
        check(view, ST_MENU);
        wait_view(ST_NORMAL, 80);
        cycles(2);
        check(applied, exp_s);
        check(lcd, exp_s);
        $display("test timeout end");

        for (int i = 0; i < 4; i++) begin
            pll_unlock = 4'h1 << i;
            cycles(3);
            check(alarm_led, 1'b1);
            check(alarm_relay, 1'b1);
            pll_unlock = 4'h0;
            cycles(3);
            check(alarm_led, 1'b0);
            check(alarm_relay, 1'b0);
        end
        $display("test alarm end");

        mute_pulse = 1'b1;
        cycles(1);
        mute_pulse = 1'b0;
        cycles(3);
        exp_s.mute = 1'b1;
        check(mute_led, 1'b1);
        check(writes, w0 + 2);
        check(nv_in, exp_s);
        do_reset();
        check(mute_led, 1'b1);
        $display("test power loss end");
        results();
    end
endmodule : fpm_menu_ctrl_bench
`default_nettype wire
